// ===== logic/pks_pkg.sv
// Purpose: Shared constants for the public-key engine status and version bank
// Assumes: One clock, registers at 32-bit aligned byte addresses
// Notes:   Command codes outside the inversion pair are local choices
package pks_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [31:0] PKS_OFS_CMD      = 32'h5000_6004;
  localparam logic [31:0] PKS_OFS_CTRL     = 32'h5000_6008;
  localparam logic [31:0] PKS_OFS_STATUS   = 32'h5000_600c;
  localparam logic [31:0] PKS_OFS_VERSION  = 32'h5000_6010;
  localparam logic [31:0] PKS_OFS_IRQ_STAT = 32'h5000_6014;
  localparam logic [31:0] PKS_OFS_IRQ_MASK = 32'h5000_6018;

  // ************************************************************
  // Widths and field positions
  // ************************************************************
  localparam int unsigned PKS_DW        = 32;
  localparam int unsigned PKS_CMD_W     = 7;
  localparam int unsigned PKS_GRP_LO    = 4;
  localparam int unsigned PKS_GRP_W     = 3;
  localparam int unsigned PKS_NIB_W     = 4;
  localparam int unsigned PKS_START_BIT = 0;
  localparam int unsigned PKS_BIT_BUSY  = 16;
  localparam int unsigned PKS_BIT_PRIME = 12;
  localparam int unsigned PKS_BIT_NOINV = 11;
  localparam int unsigned PKS_BIT_COEF  = 10;
  localparam int unsigned PKS_BIT_SIG   = 9;
  localparam int unsigned PKS_BIT_ORDER = 7;
  localparam int unsigned PKS_BIT_PAIR  = 6;
  localparam int unsigned PKS_BIT_INF   = 5;
  localparam int unsigned PKS_BIT_OFFC  = 4;
  localparam int unsigned PKS_FAIL_LO   = 0;
  localparam int unsigned PKS_FAIL_W    = 4;
  localparam int unsigned PKS_HVN_LO    = 8;
  localparam int unsigned PKS_SVN_LO    = 0;
  localparam int unsigned PKS_VER_W     = 8;

  // Order of result flags inside the flag vector
  localparam int unsigned PKS_NFLAG    = 8;
  localparam int unsigned PKS_F_PRIME  = 0;
  localparam int unsigned PKS_F_NOINV  = 1;
  localparam int unsigned PKS_F_COEF   = 2;
  localparam int unsigned PKS_F_SIG    = 3;
  localparam int unsigned PKS_F_ORDER  = 4;
  localparam int unsigned PKS_F_PAIR   = 5;
  localparam int unsigned PKS_F_INF    = 6;
  localparam int unsigned PKS_F_OFFC   = 7;

  // Interrupt status layout
  localparam int unsigned PKS_IRQ_W    = 2;
  localparam int unsigned PKS_IRQ_DONE = 0;
  localparam int unsigned PKS_IRQ_ERR  = 1;

  // ************************************************************
  // Command encodings
  // ************************************************************
  localparam logic [2:0] PKS_GRP_PRIMITIVE = 3'h0;
  localparam logic [3:0] PKS_NIB_INV_ODD   = 4'h6;
  localparam logic [3:0] PKS_NIB_INV_EVEN  = 4'h9;
  localparam logic [6:0] PKS_CMD_PRIME     = 7'h0d;
  localparam logic [6:0] PKS_CMD_COEF_CHK  = 7'h13;
  localparam logic [6:0] PKS_CMD_CHECK_N   = 7'h15;
  localparam logic [6:0] PKS_CMD_CHECK_XY  = 7'h16;
  localparam logic [6:0] PKS_CMD_CHECK_PT  = 7'h17;
  localparam logic [6:0] PKS_CMD_ECDSA_GEN = 7'h20;
  localparam logic [6:0] PKS_CMD_ECDSA_VER = 7'h21;
  localparam logic [6:0] PKS_CMD_DSA_GEN   = 7'h22;
  localparam logic [6:0] PKS_CMD_DSA_VER   = 7'h23;

  // ************************************************************
  // Run controller states
  // ************************************************************
  typedef enum logic [0:0] {
    PKS_IDLE = 1'b0,
    PKS_BUSY = 1'b1
  } pks_run_t;

endpackage

// ===== logic/pks_hold_reg.sv
// Purpose: Result holder that loads only on its update strobe
// Assumes: Update strobe from logic on mclk
// Notes:   Clears to zero on reset
`timescale 1ns/1ps
`default_nettype none
module pks_hold_reg #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         upd,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // Keeps value until the next updating command
  always_comb
  begin
    nxt_q = upd ? din : q_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign q = q_ff;
endmodule
`default_nettype wire

// ===== logic/pks_run_ctrl.sv
// Purpose: Start and busy control of the arithmetic core
// Assumes: Core done is a one-cycle pulse on mclk
// Notes:   Done outside a run is ignored
`timescale 1ns/1ps
`default_nettype none
module pks_run_ctrl
  import pks_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic start_req,
  input  wire logic core_done,
  output logic      busy,
  output logic      start_pulse,
  output logic      done_pulse
);
  pks_run_t state_ff;
  pks_run_t nxt_state;
  logic     start_ff;
  logic     nxt_start;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    case (state_ff)
      PKS_IDLE:
      begin
        if (start_req)
        begin
          nxt_state = PKS_BUSY;
          nxt_start = 1'b1;
        end
      end
      PKS_BUSY:
      begin
        // Start requests here are dropped
        if (core_done)
          nxt_state = PKS_IDLE;
      end
      default:
      begin
        nxt_state = PKS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_ff <= PKS_IDLE;
      start_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      start_ff <= nxt_start;
    end
  end

  assign busy        = (state_ff == PKS_BUSY);
  assign start_pulse = start_ff;
  assign done_pulse  = core_done && (state_ff == PKS_BUSY);
endmodule
`default_nettype wire

// ===== logic/pks_engine_regs.sv
// Purpose: Status, version and start registers of the public-key engine
// Assumes: Core signals and register port on mclk; plain one-cycle strobes
// Notes:   Read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Busy bit high from accepted start until the core reports completion.
// - Primality bit: zero probably prime, one composite, after a primality test.
// - Non-invertible flag set when an inversion operand has no inverse.
// - Coefficient-invalid flag refreshed only by the coefficient validation command.
// - Signature-reject flag updated after every signature generate or verify command.
// - Order-invalid flag updated only by the order validation command.
// - Pair-invalid flag set when x or y not below the prime.
// - Infinity flag set or cleared after every elliptic-curve operation.
// - Off-curve flag updated by the point-on-curve check command.
// - Four-bit field holds index of last failing point.
// - Hardware version code read-only in version bits 15:8.
// - Firmware version code read-only in version bits 7:0.
// - Start ignored while busy; start bit self-clears when operation finishes.
module pks_engine_regs
  import pks_pkg::*;
#(
  // Arbitrary value, not tied to any real part
  parameter logic [7:0] HW_VERSION = 8'h5a
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic [PKS_DW-1:0]         reg_addr,
  input  wire logic [PKS_DW-1:0]         reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [PKS_DW-1:0]         reg_rdata,
  output logic                           core_start,
  output logic      [PKS_CMD_W-1:0]      core_opcode,
  input  wire logic                      core_done,
  input  wire logic                      core_prime_composite,
  input  wire logic                      core_no_inverse,
  input  wire logic                      core_coef_bad,
  input  wire logic                      core_sig_bad,
  input  wire logic                      core_order_bad,
  input  wire logic                      core_pair_bad,
  input  wire logic                      core_at_infinity,
  input  wire logic                      core_off_curve,
  input  wire logic [PKS_FAIL_W-1:0]     core_fail_index,
  input  wire logic                      core_fw_we,
  input  wire logic [PKS_VER_W-1:0]      core_fw_data,
  output logic                           irq
);
  import pks_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [PKS_DW-1:0]    rdata_ff;
  logic [PKS_DW-1:0]    nxt_rdata;
  logic [PKS_CMD_W-1:0] cmd_ff;
  logic [PKS_CMD_W-1:0] nxt_cmd;
  logic [PKS_CMD_W-1:0] run_cmd_ff;
  logic [PKS_CMD_W-1:0] nxt_run_cmd;
  logic [PKS_IRQ_W-1:0] irq_stat_ff;
  logic [PKS_IRQ_W-1:0] nxt_irq_stat;
  logic [PKS_IRQ_W-1:0] irq_mask_ff;
  logic [PKS_IRQ_W-1:0] nxt_irq_mask;
  logic                 irq_ff;
  logic                 nxt_irq;
  logic                 busy;
  logic                 start_pulse;
  logic                 done_pulse;
  logic                 start_req;
  logic [PKS_NFLAG-1:0] flag_upd;
  logic [PKS_NFLAG-1:0] flag_val;
  logic [PKS_NFLAG-1:0] flag_q;
  logic [PKS_FAIL_W-1:0] fail_idx;
  logic                 fail_upd;
  logic [PKS_VER_W-1:0] fw_ver;
  logic [PKS_DW-1:0]    status_word;
  logic [PKS_DW-1:0]    version_word;
  logic [PKS_DW-1:0]    ctrl_word;
  logic                 is_inv;
  logic                 is_sig;
  logic                 is_ecc;
  logic [PKS_IRQ_W-1:0] irq_evt;
  logic [PKS_IRQ_W-1:0] irq_clr;

  // ************************************************************
  // Start and busy
  // ************************************************************
  // A start write while busy is simply dropped
  assign start_req = reg_wr && (reg_addr == PKS_OFS_CTRL)
                     && reg_wdata[PKS_START_BIT];

  pks_run_ctrl u_run (
    .mclk        (mclk),
    .rstn        (rstn),
    .start_req   (start_req),
    .core_done   (core_done),
    .busy        (busy),
    .start_pulse (start_pulse),
    .done_pulse  (done_pulse)
  );

  // ************************************************************
  // Command register and running command
  // ************************************************************
  // Running command is frozen at start so later writes cannot skew flags
  always_comb
  begin
    nxt_cmd     = cmd_ff;
    nxt_run_cmd = run_cmd_ff;
    if (reg_wr && (reg_addr == PKS_OFS_CMD))
      nxt_cmd = reg_wdata[PKS_CMD_W-1:0];
    if (start_req && !busy)
      nxt_run_cmd = cmd_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cmd_ff     <= '0;
      run_cmd_ff <= '0;
    end
    else
    begin
      cmd_ff     <= nxt_cmd;
      run_cmd_ff <= nxt_run_cmd;
    end
  end

  // ************************************************************
  // Command classes
  // ************************************************************
  always_comb
  begin
    is_inv = (run_cmd_ff[PKS_GRP_LO +: PKS_GRP_W] == PKS_GRP_PRIMITIVE)
             && ((run_cmd_ff[PKS_NIB_W-1:0] == PKS_NIB_INV_ODD)
             || (run_cmd_ff[PKS_NIB_W-1:0] == PKS_NIB_INV_EVEN));
    is_sig = (run_cmd_ff == PKS_CMD_ECDSA_GEN) || (run_cmd_ff == PKS_CMD_ECDSA_VER)
             || (run_cmd_ff == PKS_CMD_DSA_GEN) || (run_cmd_ff == PKS_CMD_DSA_VER);
    is_ecc = (run_cmd_ff[PKS_GRP_LO +: PKS_GRP_W] != PKS_GRP_PRIMITIVE);
  end

  // ************************************************************
  // Result flag updates
  // ************************************************************
  // Flags move only at completion of their own command class
  always_comb
  begin
    flag_upd              = '0;
    flag_val              = '0;
    flag_upd[PKS_F_PRIME] = done_pulse && (run_cmd_ff == PKS_CMD_PRIME);
    flag_val[PKS_F_PRIME] = core_prime_composite;
    flag_upd[PKS_F_NOINV] = done_pulse && is_inv;
    flag_val[PKS_F_NOINV] = core_no_inverse;
    flag_upd[PKS_F_COEF]  = done_pulse && (run_cmd_ff == PKS_CMD_COEF_CHK);
    flag_val[PKS_F_COEF]  = core_coef_bad;
    flag_upd[PKS_F_SIG]   = done_pulse && is_sig;
    flag_val[PKS_F_SIG]   = core_sig_bad;
    flag_upd[PKS_F_ORDER] = done_pulse && (run_cmd_ff == PKS_CMD_CHECK_N);
    flag_val[PKS_F_ORDER] = core_order_bad;
    flag_upd[PKS_F_PAIR]  = done_pulse && (run_cmd_ff == PKS_CMD_CHECK_XY);
    flag_val[PKS_F_PAIR]  = core_pair_bad;
    flag_upd[PKS_F_INF]   = done_pulse && is_ecc;
    flag_val[PKS_F_INF]   = core_at_infinity;
    flag_upd[PKS_F_OFFC]  = done_pulse && (run_cmd_ff == PKS_CMD_CHECK_PT);
    flag_val[PKS_F_OFFC]  = core_off_curve;
  end

  // Holders never see bus writes, so they keep values between commands
  genvar gi;
  generate
    for (gi = 0; gi < PKS_NFLAG; gi = gi + 1)
    begin : g_flag
      pks_hold_reg #(
        .W (1)
      ) u_flag (
        .mclk (mclk),
        .rstn (rstn),
        .upd  (flag_upd[gi]),
        .din  (flag_val[gi]),
        .q    (flag_q[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Failing point index
  // ************************************************************
  assign fail_upd = done_pulse && ((flag_upd[PKS_F_OFFC] && core_off_curve)
                    || (flag_upd[PKS_F_PAIR] && core_pair_bad)
                    || (flag_upd[PKS_F_INF] && core_at_infinity));

  pks_hold_reg #(
    .W (PKS_FAIL_W)
  ) u_fail (
    .mclk (mclk),
    .rstn (rstn),
    .upd  (fail_upd),
    .din  (core_fail_index),
    .q    (fail_idx)
  );

  // ************************************************************
  // Firmware version byte
  // ************************************************************
  // Engine reuses this byte; read it before the first command
  pks_hold_reg #(
    .W (PKS_VER_W)
  ) u_fw (
    .mclk (mclk),
    .rstn (rstn),
    .upd  (core_fw_we),
    .din  (core_fw_data),
    .q    (fw_ver)
  );

  // ************************************************************
  // Read words
  // ************************************************************
  always_comb
  begin
    status_word                                = '0;
    status_word[PKS_BIT_BUSY]                  = busy;
    status_word[PKS_BIT_PRIME]                 = flag_q[PKS_F_PRIME];
    status_word[PKS_BIT_NOINV]                 = flag_q[PKS_F_NOINV];
    status_word[PKS_BIT_COEF]                  = flag_q[PKS_F_COEF];
    status_word[PKS_BIT_SIG]                   = flag_q[PKS_F_SIG];
    status_word[PKS_BIT_ORDER]                 = flag_q[PKS_F_ORDER];
    status_word[PKS_BIT_PAIR]                  = flag_q[PKS_F_PAIR];
    status_word[PKS_BIT_INF]                   = flag_q[PKS_F_INF];
    status_word[PKS_BIT_OFFC]                  = flag_q[PKS_F_OFFC];
    status_word[PKS_FAIL_LO +: PKS_FAIL_W]     = fail_idx;
    version_word                               = '0;
    version_word[PKS_HVN_LO +: PKS_VER_W]      = HW_VERSION;
    version_word[PKS_SVN_LO +: PKS_VER_W]      = fw_ver;
    ctrl_word                                  = '0;
    ctrl_word[PKS_START_BIT]                   = busy;
  end

  // Unmapped addresses read as zero
  always_comb
  begin
    nxt_rdata = '0;
    if (reg_rd)
    begin
      if (reg_addr == PKS_OFS_CMD)
        nxt_rdata[PKS_CMD_W-1:0] = cmd_ff;
      else if (reg_addr == PKS_OFS_CTRL)
        nxt_rdata = ctrl_word;
      else if (reg_addr == PKS_OFS_STATUS)
        nxt_rdata = status_word;
      else if (reg_addr == PKS_OFS_VERSION)
        nxt_rdata = version_word;
      else if (reg_addr == PKS_OFS_IRQ_STAT)
        nxt_rdata[PKS_IRQ_W-1:0] = irq_stat_ff;
      else if (reg_addr == PKS_OFS_IRQ_MASK)
        nxt_rdata[PKS_IRQ_W-1:0] = irq_mask_ff;
      else
        nxt_rdata = '0;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // Set beats write-one clear in the same cycle
  always_comb
  begin
    irq_evt               = '0;
    irq_evt[PKS_IRQ_DONE] = done_pulse;
    irq_evt[PKS_IRQ_ERR]  = |(flag_upd & flag_val & ~(PKS_NFLAG'(1) << PKS_F_INF)
                              & ~(PKS_NFLAG'(1) << PKS_F_PRIME));
    irq_clr               = '0;
    nxt_irq_mask          = irq_mask_ff;
    if (reg_wr && (reg_addr == PKS_OFS_IRQ_STAT))
      irq_clr = reg_wdata[PKS_IRQ_W-1:0];
    if (reg_wr && (reg_addr == PKS_OFS_IRQ_MASK))
      nxt_irq_mask = reg_wdata[PKS_IRQ_W-1:0];
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;
    nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rdata_ff    <= '0;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      rdata_ff    <= nxt_rdata;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff      <= nxt_irq;
    end
  end

  // Outputs all come from flip-flops
  assign reg_rdata   = rdata_ff;
  assign core_start  = start_pulse;
  assign core_opcode = run_cmd_ff;
  assign irq         = irq_ff;

endmodule
`default_nettype wire

// ===== tb/pks_core_model.sv
// Purpose: Behavioural arithmetic core answering start pulses
// Assumes: Bench sets latency and results before each start
// Notes:   Results inverted outside done
`timescale 1ns/1ps
`default_nettype none
module pks_core_model (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       core_start,
  input  wire logic [6:0] core_opcode,
  input  wire logic [7:0] lat,
  input  wire logic [7:0] res,
  input  wire logic [3:0] idx,
  output logic            core_done,
  output logic      [7:0] flags,
  output logic      [3:0] fail_index,
  output logic            fw_we,
  output logic      [7:0] fw_data
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  // ************
  // Latency counter
  // ************
  always_comb
  begin
    nxt_cnt = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
    if (core_start)
      nxt_cnt = lat;
  end
  always_ff @(posedge mclk)
  begin
    cnt_ff <= rstn ? nxt_cnt : 8'h00;
  end
  // Inverted results catch sampling outside the done cycle
  assign core_done  = (cnt_ff == 8'h01);
  assign flags      = core_done ? res : ~res;
  assign fail_index = core_done ? idx : ~idx;
  assign fw_we      = core_done;
  assign fw_data    = {1'b1, core_opcode};
endmodule
`default_nettype wire

// ===== tb/pks_engine_regs_assertions.sv
// Purpose: Port checks for the engine status and version bank
// Assumes: One mclk domain, synchronous active-low rstn
// Notes:   Busy and firmware byte rebuilt from core pulses
`timescale 1ns/1ps
`default_nettype none
module pks_engine_regs_assertions
  import pks_pkg::*;
#(
  parameter logic [7:0] HW_VERSION = 8'h5a // Arbitrary
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        core_start,
  input wire logic [6:0]  core_opcode,
  input wire logic        core_done,
  input wire logic        core_prime_composite,
  input wire logic        core_no_inverse,
  input wire logic        core_sig_bad,
  input wire logic        core_at_infinity,
  input wire logic        core_fw_we,
  input wire logic [7:0]  core_fw_data
);
  logic       run_ff;
  logic [7:0] fw_ff;
  logic       busy_c;
  logic       st_rd;
  logic       ver_rd;
  logic       quiet;
  logic       done_ok;
  always_ff @(posedge mclk)
  begin
    run_ff <= rstn & (core_start | (run_ff & ~core_done));
    fw_ff  <= !rstn ? 8'h00 : (core_fw_we ? core_fw_data : fw_ff);
  end
  assign busy_c  = core_start | run_ff;
  assign st_rd   = reg_rd && reg_addr == PKS_OFS_STATUS;
  assign ver_rd  = reg_rd && reg_addr == PKS_OFS_VERSION;
  assign quiet   = !core_start && !core_done;
  assign done_ok = core_done && run_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ************
  // Completion steps
  // ************
  sequence done_sig_s;
    done_ok && core_opcode[6:2] == 5'h08;
  endsequence
  sequence done_inv_s;
    done_ok && core_opcode[6:4] == PKS_GRP_PRIMITIVE &&
      (core_opcode[3:0] == PKS_NIB_INV_ODD || core_opcode[3:0] == PKS_NIB_INV_EVEN);
  endsequence
  sequence done_ecc_s;
    done_ok && core_opcode[6:4] != 3'h0;
  endsequence
  start_accept_a: assert property (
    reg_wr && reg_addr == PKS_OFS_CTRL && reg_wdata[0] && !busy_c |=> core_start) else $error("start lost");
  start_ignore_a: assert property (
    reg_wr && reg_addr == PKS_OFS_CTRL && busy_c |=> !core_start) else $error("start taken while busy");
  busy_read_a: assert property (
    st_rd |=> reg_rdata[PKS_BIT_BUSY] == $past(busy_c)) else $error("busy bit wrong");
  busy_clear_a: assert property (
    done_ok ##1 st_rd |=> !reg_rdata[PKS_BIT_BUSY]) else $error("busy after done");
  hw_version_a: assert property (
    ver_rd |=> reg_rdata[15:8] == HW_VERSION) else $error("hardware version wrong");
  fw_version_a: assert property (
    ver_rd |=> reg_rdata[7:0] == $past(fw_ff)) else $error("firmware version wrong");
  status_hold_a: assert property (
    (st_rd && quiet) ##1 (reg_wr && reg_addr == PKS_OFS_STATUS && quiet) ##1 (st_rd && quiet)
      |=> reg_rdata == $past(reg_rdata, 2)) else $error("status changed by write");
  prime_flag_a: assert property (
    (done_ok && core_opcode == PKS_CMD_PRIME) ##1 st_rd |=> reg_rdata[PKS_BIT_PRIME] == $past(core_prime_composite, 2))
    else $error("prime flag wrong");
  sig_flag_a: assert property (
    done_sig_s ##1 st_rd |=> reg_rdata[PKS_BIT_SIG] == $past(core_sig_bad, 2)) else $error("sig flag wrong");
  noinv_flag_a: assert property (
    done_inv_s ##1 st_rd |=> reg_rdata[PKS_BIT_NOINV] == $past(core_no_inverse, 2)) else $error("noinv wrong");
  inf_flag_a: assert property (
    done_ecc_s ##1 st_rd |=> reg_rdata[PKS_BIT_INF] == $past(core_at_infinity, 2)) else $error("inf flag wrong");
endmodule
bind pks_engine_regs pks_engine_regs_assertions #(.HW_VERSION(HW_VERSION)) u_chk (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_start(core_start), .core_opcode(core_opcode),
  .core_done(core_done), .core_prime_composite(core_prime_composite), .core_no_inverse(core_no_inverse),
  .core_sig_bad(core_sig_bad), .core_at_infinity(core_at_infinity), .core_fw_we(core_fw_we),
  .core_fw_data(core_fw_data)
);
`default_nettype wire

// ===== tb/pks_engine_regs_tb.sv
// Purpose: Self-checking bench for the engine status and version bank
// Assumes: Core model answers after a bench-set latency
// Notes:   Row table covers each result command; odd cases follow
`timescale 1ns/1ps
`default_nettype none
module pks_engine_regs_tb;
  import pks_pkg::*;
  localparam logic [7:0] HWV = 8'h3c; // Arbitrary version code
  typedef struct packed {
    logic [6:0]  op;
    logic [7:0]  res;
    logic [3:0]  idx;
    logic [31:0] st;
  } pks_row_t;
  pks_row_t rows [13] = '{
    '{7'h0d, 8'hff, 4'h3, 32'h1000}, '{7'h06, 8'hff, 4'h5, 32'h1800},
    '{7'h13, 8'hff, 4'h7, 32'h1c27}, '{7'h15, 8'h00, 4'h9, 32'h1c07},
    '{7'h16, 8'hff, 4'ha, 32'h1c6a}, '{7'h17, 8'h80, 4'h2, 32'h1c52},
    '{7'h20, 8'hff, 4'h4, 32'h1e74}, '{7'h21, 8'h00, 4'h8, 32'h1c54},
    '{7'h22, 8'h08, 4'h1, 32'h1e54}, '{7'h23, 8'h00, 4'hb, 32'h1c54},
    '{7'h09, 8'h00, 4'hc, 32'h1454}, '{7'h0d, 8'h00, 4'hd, 32'h0454},
    '{7'h15, 8'h10, 4'h6, 32'h04d4}};
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        core_start;
  logic [6:0]  core_opcode;
  logic        core_done;
  logic [7:0]  flags;
  logic [3:0]  fail_index;
  logic        fw_we;
  logic [7:0]  fw_data;
  logic        irq;
  logic [7:0]  lat = 8'h01;
  logic [7:0]  res = 8'h00;
  logic [3:0]  idx = 4'h0;
  int          fail_count = 0;
  int          comparisons = 0;
  int          starts = 0;
  pks_engine_regs #(.HW_VERSION(HWV)) u_dut (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_start(core_start), .core_opcode(core_opcode),
    .core_done(core_done), .core_prime_composite(flags[PKS_F_PRIME]), .core_no_inverse(flags[PKS_F_NOINV]),
    .core_coef_bad(flags[PKS_F_COEF]), .core_sig_bad(flags[PKS_F_SIG]), .core_order_bad(flags[PKS_F_ORDER]),
    .core_pair_bad(flags[PKS_F_PAIR]), .core_at_infinity(flags[PKS_F_INF]),
    .core_off_curve(flags[PKS_F_OFFC]), .core_fail_index(fail_index), .core_fw_we(fw_we),
    .core_fw_data(fw_data), .irq(irq));
  pks_core_model u_core (
    .mclk(mclk), .rstn(rstn), .core_start(core_start), .core_opcode(core_opcode), .lat(lat),
    .res(res), .idx(idx), .core_done(core_done), .flags(flags), .fail_index(fail_index),
    .fw_we(fw_we), .fw_data(fw_data));
  initial
    forever #5 mclk = ~mclk;
  always @(posedge mclk)
    if (core_start === 1'b1)
      starts <= starts + 1;
  // ************
  // Bus and compare tasks
  // ************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Bounded so a silent core cannot hang the run
  task automatic wait_done;
    #1;
    for (int k = 0; k < 300 && core_done !== 1'b1; k++)
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ************
  // Main sequence
  // ************
  initial
  begin
    logic [31:0] d;
    int          s0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rd(PKS_OFS_STATUS, d);
    chk("status reset", 32'h0, d);
    wr(PKS_OFS_VERSION, 32'hffff_ffff);
    rd(PKS_OFS_VERSION, d);
    chk("version reset", {16'h0, HWV, 8'h00}, d);
    rd(32'h5000_6020, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    foreach (rows[n])
    begin
      res <= rows[n].res;
      idx <= rows[n].idx;
      lat <= 8'h01 + 8'(n);
      wr(PKS_OFS_CMD, {25'h0, rows[n].op});
      wr(PKS_OFS_CTRL, 32'h1);
      wait_done;
      rd(PKS_OFS_STATUS, d);
      chk("status", rows[n].st, d);
      rd(PKS_OFS_VERSION, d);
      chk("version", {16'h0, HWV, 1'b1, rows[n].op}, d);
    end
    $display("test row table done");
    @(posedge mclk);
    reg_addr <= PKS_OFS_STATUS;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_wr   <= 1'b1;
    #1;
    chk("status before write", 32'h04d4, reg_rdata);
    @(posedge mclk);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk("status after write", 32'h04d4, reg_rdata);
    $display("test status hold done");
    s0 = starts;
    res <= 8'h10;
    lat <= 8'h28;
    wr(PKS_OFS_CTRL, 32'h1);
    rd(PKS_OFS_STATUS, d);
    chk("busy set", 32'h0001_04d4, d);
    wr(PKS_OFS_CTRL, 32'h1);
    rd(PKS_OFS_CTRL, d);
    chk("start held", 32'h1, d);
    wait_done;
    rd(PKS_OFS_STATUS, d);
    chk("busy clear", 32'h04d4, d);
    rd(PKS_OFS_CTRL, d);
    chk("start cleared", 32'h0, d);
    chk("start count", 32'h1, 32'(starts - s0));
    $display("test busy done");
    chk("irq masked", 32'h0, 32'(irq));
    rd(PKS_OFS_IRQ_STAT, d);
    chk("irq status", 32'h3, d);
    wr(PKS_OFS_IRQ_MASK, 32'h2);
    @(posedge mclk);
    #1;
    chk("irq raised", 32'h1, 32'(irq));
    wr(PKS_OFS_IRQ_STAT, 32'h2);
    @(posedge mclk);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    rd(PKS_OFS_IRQ_STAT, d);
    chk("irq status left", 32'h1, d);
    $display("test irq done");
    complete_run;
  end
  // Run needs under 2000 cycles; 10000 leaves margin
  initial
  begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    complete_run;
  end
endmodule
`default_nettype wire
